/* File: core/sipm_pkg.sv */
// Constants and types for the status interrupt and supply monitor
// Functional notes
// - Supply status register at 02, 1 means fault
// - Unmasked supply fault raises sequencer fault always
// - Edges on input-configured general pins interrupt
// - Interrupt masks stop masked sources interrupting
// - Set acknowledge bits first, then pull line low
// - Hold line low, freeze acknowledge contents
// - Ignore further changes while line is low
// - Host writes 0 to ack; line releases
// - Abandoned host transfer keeps line low
// - No timeout ever releases a pending interrupt
// - Power, charger, thermal, ADC, supply sources monitored
// - Status valid only after normal operation entered
// - Conversion complete is bit 7, interrupt source
// - ADC limits and high impedance are sources
package sipm_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_SUPPLY_GOOD_STATUS = 8'h02;
  localparam logic [7:0] ADDR_IRQ_MASK_A         = 8'h03;
  localparam logic [7:0] ADDR_IRQ_MASK_B         = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ACK_REG_A      = 8'h05;
  localparam logic [7:0] ADDR_IRQ_ACK_REG_B      = 8'h06;
  localparam logic [7:0] ADDR_SUPPLY_FAULT_MASK  = 8'h07;

  // Reset values
  localparam logic [7:0] RST_SUPPLY_FAULT_MASK = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK_A        = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK_B        = 8'h00;
  localparam logic [7:0] RST_ACK               = 8'h00;
  localparam logic [7:0] RST_RDATA             = 8'h00;

  // Field positions in irq_ack_reg_b and its mask
  localparam int BIT_CONV_DONE   = 7;
  localparam int BIT_AIN_HIZ     = 6;
  localparam int BIT_GP_PIN_B    = 5;
  localparam int BIT_GP_PIN_A    = 4;
  localparam int BIT_THERMAL     = 3;
  localparam int BIT_CHG_STATUS  = 2;
  localparam int BIT_ADC_ABOVE   = 1;
  localparam int BIT_ADC_BELOW   = 0;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // Register access port from the serial host interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sipm_reg_req_t;

  // Same-clock status inputs from charger, power path and converter
  typedef struct packed {
    logic       conv_done;
    logic       ain_hiz;
    logic       thermal;
    logic       adc_above;
    logic       adc_below;
    logic [7:0] chg_status;
  } sipm_status_t;

  // Whole register state of the top module
  typedef struct packed {
    logic [7:0]   sup_mask;
    logic [7:0]   irq_mask_a;
    logic [7:0]   irq_mask_b;
    logic [7:0]   ack_a;
    logic [7:0]   ack_b;
    logic         pend;
    logic         int_n;
    logic         pg_fault;
    logic         live;
    logic [7:0]   rdata;
    logic         rvalid;
    logic [7:0]   sup_prev;
    logic [1:0]   gp_prev;
    sipm_status_t st_prev;
  } sipm_state_t;

endpackage

/* File: core/sipm_sync.sv */
// Three-stage pin synchroniser with agreement filter
module sipm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sipm_sync_st_t;

  sipm_sync_st_t st_r;
  sipm_sync_st_t st_nxt;

  // Width must be at least one bit
  initial begin
    if (W < 1 || sipm_pkg::SYNC_STAGES != 3) begin
      $error("sipm_sync: unsupported width or depth");
    end
  end

  // Stage one is read by stage two only; change taken once 2 and 3 agree
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.q;

endmodule

/* File: core/sipm_top.sv */
// Status interrupt controller with supply power-good monitor
module sipm_top (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_arst_n,
  input  sipm_pkg::sipm_reg_req_t     i_reg_req,
  input  wire logic [7:0]             i_supply_fault,
  input  wire logic                   i_gp_pin_a,
  input  wire logic                   i_gp_pin_b,
  input  wire logic                   i_gp_pin_a_is_input,
  input  wire logic                   i_gp_pin_b_is_input,
  input  sipm_pkg::sipm_status_t      i_status,
  input  wire logic                   i_normal_mode,
  output logic                        o_int_n,
  output logic                        o_supply_good_status_fault,
  output logic [7:0]                  o_reg_rdata,
  output logic                        o_reg_rvalid
);

  sipm_pkg::sipm_state_t st_r;
  sipm_pkg::sipm_state_t st_nxt;

  logic [7:0] sup_sync;
  logic [1:0] gp_sync;

  // Supply comparators are analog and the general pins are external
  sipm_sync #(
    .W (8)
  ) u_sup_sync (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_d       (i_supply_fault),
    .o_q       (sup_sync)
  );

  sipm_sync #(
    .W (2)
  ) u_gp_sync (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_d       ({i_gp_pin_b, i_gp_pin_a}),
    .o_q       (gp_sync)
  );

  // Per-source change pulses
  logic [7:0] chg_a;
  logic [7:0] chg_b;
  logic [1:0] gp_edge;

  always_comb begin
    chg_a   = sup_sync ^ st_r.sup_prev;
    gp_edge = (gp_sync ^ st_r.gp_prev)
            & {i_gp_pin_b_is_input, i_gp_pin_a_is_input};
    chg_b   = 8'h00;
    chg_b[sipm_pkg::BIT_CONV_DONE] =
      i_status.conv_done ^ st_r.st_prev.conv_done;
    chg_b[sipm_pkg::BIT_AIN_HIZ] =
      i_status.ain_hiz ^ st_r.st_prev.ain_hiz;
    chg_b[sipm_pkg::BIT_GP_PIN_B] = gp_edge[1];
    chg_b[sipm_pkg::BIT_GP_PIN_A] = gp_edge[0];
    chg_b[sipm_pkg::BIT_THERMAL] =
      i_status.thermal ^ st_r.st_prev.thermal;
    // Charger, power input and battery bits share one source
    chg_b[sipm_pkg::BIT_CHG_STATUS] =
      |(i_status.chg_status ^ st_r.st_prev.chg_status);
    chg_b[sipm_pkg::BIT_ADC_ABOVE] =
      i_status.adc_above ^ st_r.st_prev.adc_above;
    chg_b[sipm_pkg::BIT_ADC_BELOW] =
      i_status.adc_below ^ st_r.st_prev.adc_below;
  end

  // Unmasked events, armed only once normal operation was reached
  logic [7:0] evt_a;
  logic [7:0] evt_b;
  logic       evt_any;

  always_comb begin
    evt_a   = chg_a & ~st_r.irq_mask_a & {8{st_r.live}};
    evt_b   = chg_b & ~st_r.irq_mask_b & {8{st_r.live}};
    evt_any = |{evt_a, evt_b};
  end

  // Write decode and acknowledge handling
  logic [7:0] ack_a_clr;
  logic [7:0] ack_b_clr;
  logic       ack_wr;

  always_comb begin
    ack_a_clr = st_r.ack_a;
    ack_b_clr = st_r.ack_b;
    ack_wr    = 1'b0;
    // Writing 1 leaves a flag alone; only a completed write acts
    if (i_reg_req.wr) begin
      if (i_reg_req.addr == sipm_pkg::ADDR_IRQ_ACK_REG_A) begin
        ack_a_clr = st_r.ack_a & i_reg_req.wdata;
        ack_wr    = 1'b1;
      end
      if (i_reg_req.addr == sipm_pkg::ADDR_IRQ_ACK_REG_B) begin
        ack_b_clr = st_r.ack_b & i_reg_req.wdata;
        ack_wr    = 1'b1;
      end
    end
  end

  // Single next-state process for all registers
  always_comb begin
    st_nxt = st_r;

    // Previous values for change detection
    st_nxt.sup_prev = sup_sync;
    st_nxt.gp_prev  = gp_sync;
    st_nxt.st_prev  = i_status;

    // Sticky: status counted as valid after first normal entry
    if (i_normal_mode) begin
      st_nxt.live = 1'b1;
    end

    // Sequencer fault ignores the interrupt line level
    st_nxt.pg_fault = |(sup_sync & ~st_r.sup_mask);

    // Configuration writes
    if (i_reg_req.wr) begin
      case (i_reg_req.addr)
        sipm_pkg::ADDR_IRQ_MASK_A: begin
          st_nxt.irq_mask_a = i_reg_req.wdata;
        end
        sipm_pkg::ADDR_IRQ_MASK_B: begin
          st_nxt.irq_mask_b = i_reg_req.wdata;
        end
        sipm_pkg::ADDR_SUPPLY_FAULT_MASK: begin
          st_nxt.sup_mask = i_reg_req.wdata;
        end
        default: begin
        end
      endcase
    end

    // Pending request: ack frozen, new changes dropped, no queueing
    if (st_r.pend) begin
      st_nxt.ack_a = ack_a_clr;
      st_nxt.ack_b = ack_b_clr;
      // Release only once host has cleared every latched flag
      if (ack_wr && ack_a_clr == 8'h00 && ack_b_clr == 8'h00) begin
        st_nxt.pend = 1'b0;
      end
      // No timer anywhere can clear pend
    end else begin
      // Event wins over a clear landing in the same cycle
      st_nxt.ack_a = ack_a_clr | evt_a;
      st_nxt.ack_b = ack_b_clr | evt_b;
      if (evt_any) begin
        st_nxt.pend = 1'b1;
      end
    end

    // Line follows pend a cycle later, so ack is set first
    st_nxt.int_n = ~st_r.pend;

    // Read data, registered; unmapped offsets read zero
    st_nxt.rvalid = i_reg_req.rd;
    if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        sipm_pkg::ADDR_SUPPLY_GOOD_STATUS: begin
          st_nxt.rdata = sup_sync;
        end
        sipm_pkg::ADDR_IRQ_MASK_A: begin
          st_nxt.rdata = st_r.irq_mask_a;
        end
        sipm_pkg::ADDR_IRQ_MASK_B: begin
          st_nxt.rdata = st_r.irq_mask_b;
        end
        sipm_pkg::ADDR_IRQ_ACK_REG_A: begin
          st_nxt.rdata = st_r.ack_a;
        end
        sipm_pkg::ADDR_IRQ_ACK_REG_B: begin
          st_nxt.rdata = st_r.ack_b;
        end
        sipm_pkg::ADDR_SUPPLY_FAULT_MASK: begin
          st_nxt.rdata = st_r.sup_mask;
        end
        default: begin
          st_nxt.rdata = sipm_pkg::RST_RDATA;
        end
      endcase
    end
  end

  // Constants only under reset
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r            <= '0;
      st_r.sup_mask   <= sipm_pkg::RST_SUPPLY_FAULT_MASK;
      st_r.irq_mask_a <= sipm_pkg::RST_IRQ_MASK_A;
      st_r.irq_mask_b <= sipm_pkg::RST_IRQ_MASK_B;
      st_r.ack_a      <= sipm_pkg::RST_ACK;
      st_r.ack_b      <= sipm_pkg::RST_ACK;
      st_r.rdata      <= sipm_pkg::RST_RDATA;
      st_r.int_n      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_int_n       = st_r.int_n;
  assign o_supply_good_status_fault = st_r.pg_fault;
  assign o_reg_rdata   = st_r.rdata;
  assign o_reg_rvalid  = st_r.rvalid;

endmodule

/* File: sim/sipm_top_assertions.sv */
// Port assertions for the status interrupt block
module sipm_top_assertions (
  input wire logic               i_clk_sys,
  input wire logic               i_arst_n,
  input sipm_pkg::sipm_reg_req_t i_reg_req,
  input wire logic [7:0]         i_supply_fault,
  input wire logic               i_normal_mode,
  input wire logic               o_int_n,
  input wire logic               o_supply_good_status_fault,
  input wire logic [7:0]         o_reg_rdata,
  input wire logic               o_reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] msk_r;
  logic [7:0] unm;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // Shadow fault mask, so the sequencer output can be predicted
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      msk_r <= 8'h00;
    end else if (i_reg_req.wr && i_reg_req.addr == 8'h07) begin
      msk_r <= i_reg_req.wdata;
    end
  end
  assign unm = i_supply_fault & ~msk_r;
  // Eight quiet cycles cover the pin synchroniser lag
  sequence s_on; ($stable(unm) && unm != 8'h00)[*8]; endsequence
  sequence s_off; ($stable(unm) && unm == 8'h00)[*8]; endsequence
  sequence s_still; $stable(i_supply_fault)[*8]; endsequence
  sequence s_rd_sup; i_reg_req.rd && i_reg_req.addr == 8'h02; endsequence
  chk_rd_answer:
    assert property (i_reg_req.rd |=> o_reg_rvalid) else $error("no answer");
  chk_rvalid_only:
    assert property (!i_reg_req.rd |=> !o_reg_rvalid)
    else $error("stray rvalid");
  chk_status_read:
    assert property (s_still ##0 s_rd_sup
                     |=> o_reg_rdata == $past(i_supply_fault))
    else $error("status read wrong");
  chk_unmapped_zero:
    assert property (i_reg_req.rd && i_reg_req.addr > 8'h07
                     |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_pg_raise:
    assert property (s_on |-> o_supply_good_status_fault) else $error("fault not raised");
  chk_pg_drop:
    assert property (s_off |-> !o_supply_good_status_fault) else $error("fault not dropped");
  chk_int_held:
    assert property (!o_int_n && !i_reg_req.wr && !$past(i_reg_req.wr)
                     |=> !o_int_n)
    else $error("line released alone");
  chk_int_release:
    assert property ($rose(o_int_n) |-> $past(i_reg_req.wr, 2))
    else $error("release without write");
  chk_quiet_early:
    assert property ((!i_normal_mode)[*2] |-> o_int_n)
    else $error("early irq");
endmodule
bind sipm_top sipm_top_assertions sipm_top_assertions_inst (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg_req(i_reg_req),
  .i_supply_fault(i_supply_fault), .i_normal_mode(i_normal_mode),
  .o_int_n(o_int_n), .o_supply_good_status_fault(o_supply_good_status_fault),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid)
);

/* File: sim/sipm_host.sv */
// Host model issuing register strobes like the serial decoder
module sipm_host (
  input  wire logic               i_clk_sys,
  input  wire logic [7:0]         i_rdata,
  input  wire logic               i_rvalid,
  output sipm_pkg::sipm_reg_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus carries junk so a stale address never looks live
  initial o_req = '{1'b0, 1'b0, 8'hFF, 8'hFF};
  // Only whole transfers reach the block, abandoned ones never do
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_req = '{1'b1, 1'b0, a, d};
    @(negedge i_clk_sys);
    o_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Answer stands only in the cycle after the strobe edge, take it there
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge i_clk_sys);
    o_req = '{1'b0, 1'b1, a, ~a};
    @(negedge i_clk_sys);
    ok = i_rvalid;
    d = i_rdata;
    o_req = '{1'b0, 1'b0, ~a, a};
  endtask
endmodule

/* File: sim/sipm_top_test.sv */
// Self-checking bench for the status interrupt block
module sipm_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk, rst_n, nm, int_n, pgf, rv;
  logic                    gpa, gpb, gpa_in, gpb_in;
  logic [7:0]              flt, rdat;
  logic [12:0]             st;
  sipm_pkg::sipm_reg_req_t req;
  int                      failures, n_compared;
  // Status vector bit behind each ack_b bit except general pin bits 5 and 4
  int                      ackb[6] = '{7, 6, 3, 2, 1, 0};
  int                      stb[6] = '{12, 11, 10, 0, 9, 8};
  sipm_top sipm_top_inst (
    .i_clk_sys(clk), .i_arst_n(rst_n), .i_reg_req(req),
    .i_supply_fault(flt), .i_gp_pin_a(gpa), .i_gp_pin_b(gpb),
    .i_gp_pin_a_is_input(gpa_in), .i_gp_pin_b_is_input(gpb_in),
    .i_status(sipm_pkg::sipm_status_t'(st)), .i_normal_mode(nm),
    .o_int_n(int_n), .o_supply_good_status_fault(pgf), .o_reg_rdata(rdat),
    .o_reg_rvalid(rv));
  sipm_host sipm_host_inst (.i_clk_sys(clk), .i_rdata(rdat),
    .i_rvalid(rv), .o_req(req));
  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sipm_host_inst.wr(a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string s);
    logic [7:0] d;
    logic       ok;
    sipm_host_inst.rd(a, d, ok);
    cmp("read valid", 8'h01, {7'h00, ok});
    cmp(s, e, d);
  endtask
  task automatic tog(input int i);
    @(negedge clk);
    st[i] = ~st[i];
  endtask
  // Bounded wait; a hang ends the run at once
  task automatic wait_int(input logic lvl, input string s);
    for (int k = 0; k < 12 && int_n !== lvl; k++) @(negedge clk);
    cmp(s, {7'h00, lvl}, {7'h00, int_n});
    if (int_n !== lvl) test_done();
  endtask
  task automatic hold_int(input logic lvl, input int n, input string s);
    repeat (n) begin
      @(negedge clk);
      cmp(s, {7'h00, lvl}, {7'h00, int_n});
    end
  endtask
  task automatic irq_seen(input logic [7:0] a, input logic [7:0] e);
    wait_int(1'b0, "int low");
    rdc(a, e, "ack");
    wr(a, 8'h00);
    wait_int(1'b1, "int released");
  endtask
  task automatic t_early;
    tog(10);
    hold_int(1'b1, 6, "before normal");
    tog(10);
  endtask
  task automatic t_regs;
    for (int a = 3; a < 8; a++) begin
      rdc(8'(a), 8'h00, "reset value");
      wr(8'(a), 8'hA5);
      rdc(8'(a), (a == 5 || a == 6) ? 8'h00 : 8'hA5, "readback");
      wr(8'(a), 8'h00);
    end
    wr(8'h02, 8'hFF);
    rdc(8'h02, 8'h00, "read-only status");
    rdc(8'h40, 8'h00, "unmapped");
  endtask
  task automatic t_src;
    for (int j = 0; j < 6; j++) begin
      tog(stb[j]);
      irq_seen(8'h06, 8'(8'h01 << ackb[j]));
    end
  endtask
  task automatic t_hold;
    tog(10);
    wait_int(1'b0, "int low");
    tog(12);
    hold_int(1'b0, 40, "int held");
    wr(8'h05, 8'h00);
    hold_int(1'b0, 4, "other ack write");
    irq_seen(8'h06, 8'h08);
    hold_int(1'b1, 8, "nothing queued");
  endtask
  task automatic t_mask;
    wr(8'h04, 8'h08);
    tog(10);
    hold_int(1'b1, 8, "masked source");
    wr(8'h04, 8'h00);
  endtask
  task automatic t_gp;
    @(negedge clk);
    gpa_in = 1'b1;
    gpa = 1'b1;
    irq_seen(8'h06, 8'h10);
    @(negedge clk);
    gpa = 1'b0;
    irq_seen(8'h06, 8'h10);
    @(negedge clk);
    gpb = 1'b1;
    hold_int(1'b1, 10, "pin not input");
    gpb_in = 1'b1;
    gpb = 1'b0;
    irq_seen(8'h06, 8'h20);
  endtask
  task automatic t_pg;
    @(negedge clk);
    flt = 8'h80;
    irq_seen(8'h05, 8'h80);
    cmp("supply_good_status fault", 8'h01, {7'h00, pgf});
    repeat (8) @(negedge clk);
    rdc(8'h02, 8'h80, "supply status");
    wr(8'h07, 8'h80);
    repeat (2) @(negedge clk);
    cmp("supply_good_status masked", 8'h00, {7'h00, pgf});
  endtask
  initial begin
    {rst_n, nm, gpa, gpb, gpa_in, gpb_in} = 6'b000000;
    flt = 8'h00;
    st = 13'h0000;
    failures = 0;
    n_compared = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_early();
    nm = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_src();
    t_hold();
    t_mask();
    t_gp();
    t_pg();
    test_done();
  end
endmodule
